// file: multi_io_read_cfg.svh
/*
  Constants for the multi-line read block: command codes, phase lengths
  in serial clocks, field positions and reset values.
  Assumes it is included by bare name wherever these values are needed.
*/
`ifndef MULTI_IO_READ_CFG_SVH
`define MULTI_IO_READ_CFG_SVH

// Command codes
`define CMD_DUAL_IO_READ     8'hBB
`define CMD_QUAD_IO_READ     8'hEB
`define CMD_WORD_QUAD_READ   8'hE7
`define CMD_OCTAL_QUAD_READ  8'hE3
`define CMD_SET_BURST_WRAP   8'h77

// Phase lengths in serial clocks
`define CODE_CLOCKS          4'h8
`define ADDR_CLOCKS_DUAL     4'hC
`define ADDR_CLOCKS_QUAD     4'h6
`define MODE_CLOCKS_DUAL     4'h4
`define MODE_CLOCKS_QUAD     4'h2
`define DUMMY_CLOCKS_QUAD    4'h4
`define DUMMY_CLOCKS_WORD    4'h2
`define DUMMY_CLOCKS_OCTAL   4'h0

// Last output beat of a byte (beats per byte less one)
`define BEATS_DUAL           2'h3
`define BEATS_QUAD           2'h1

// Field positions
`define SKIP_CODE_HI         5
`define SKIP_CODE_LO         4
`define SKIP_CODE_KEY        2'h2
`define WRAP_BITS_HI         6
`define WRAP_BITS_LO         4

// Reset values
`define WRAP_BITS_RESET      3'h1
`define FIFO_DEPTH_DEFAULT   8

`endif

// file: multi_io_read_pkg.sv
/*
  Types shared by the multi-line read block.
  Assumes nothing of its surroundings.
*/
package multi_io_read_pkg;

  typedef enum logic [5:0] {
    PH_CODE   = 6'h01,
    PH_ADDR   = 6'h02,
    PH_MODE   = 6'h04,
    PH_DUMMY  = 6'h08,
    PH_DATA   = 6'h10,
    PH_IGNORE = 6'h20
  } phase_type;

endpackage

// file: link_sync.sv
/*
  Two-stage synchroniser for a group of asynchronous levels.
  Assumes each bit is sampled independently; the caller tolerates
  one cycle of skew between bits.
*/
`timescale 1ns/1ps
module link_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  // Levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      meta   <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule

// file: byte_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides and a flush.
  Assumes a single clock; flush wins over a push in the same cycle.
*/
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  input  wire logic             i_flush,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_idx;
  logic [PW-1:0]    rd_idx;
  logic [CW-1:0]    count;

  wire do_push = i_in_valid & o_in_ready;
  wire do_pop  = i_out_ready & o_out_valid;

  assign o_in_ready  = (count != CW'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data  = store[rd_idx];

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] idx);
    bump = (idx == PW'(DEPTH - 1)) ? '0 : idx + PW'(1);
  endfunction

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end else if (i_flush) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_idx <= bump(wr_idx);
      end
      if (do_pop) begin
        rd_idx <= bump(rd_idx);
      end
      count <= count + CW'(do_push) - CW'(do_pop);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (do_push && !i_flush) begin
      store[wr_idx] <= i_in_data;
    end
  end

endmodule

// file: multi_io_read_continuous_wrap.sv
/*
  Device side of the multi-line flash reads: dual, quad, word quad and
  octal word quad I/O, with continuous read (code-less re-entry) and the
  burst-wrap setting. Bytes come from a memory port with a fixed latency
  of one core cycle and pass through a small FIFO to the serial lines.
  Assumes the serial clock is at most an eighth of the core clock and
  that the host drives SPI mode 0 (sample on rise, shift on fall).
*/

// Operation
// - Mode byte bits 5-4 decide; others ignored
// - Dual mode 10 skips code next frame
// - Other mode values restore normal code decoding
// - All-ones mode byte clears continuous state
// - Quad read uses four lines, four dummies
// - Quad read refused without quad enable
// - Quad mode 10 skips code next frame
// - Wrap setting governs every quad read
// - Wrap returns to aligned section start
// - Three wrap bits: disable and length
// - Word read: even address, two dummies
// - Word read refused without quad enable
// - Word mode 10 skips code next frame
// - Wrap setting governs every word read
// - Octal read: 16-aligned address, no dummies
// - Octal read refused without quad enable
// - Dual address two bits per clock
// - Wrap disabled after reset
`timescale 1ns/1ps
`include "multi_io_read_cfg.svh"
module multi_io_read_continuous_wrap #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DEFAULT
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Serial link
  input  wire logic        i_cs_n,
  input  wire logic        i_sclk,
  input  wire logic [3:0]  i_io,
  output logic      [3:0]  o_io,
  output logic      [3:0]  o_io_oe,
  // Configuration and status
  input  wire logic        i_quad_lines_enable,
  output logic             o_continuous,
  output logic      [2:0]  o_wrap_bits,
  // Memory read port
  output logic             o_mem_rd,
  output logic      [23:0] o_mem_addr,
  input  wire logic [7:0]  i_mem_rdata
);

  // Synchronised link pins
  logic [5:0] sync_q;
  logic       sclk_d;

  link_sync #(
    .WIDTH     (6),
    .RESET_VAL (6'h20)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    ({i_cs_n, i_sclk, i_io}),
    .o_sync     (sync_q)
  );

  wire       s_cs_n = sync_q[5];
  wire       s_sclk = sync_q[4];
  wire [3:0] s_io   = sync_q[3:0];

  wire sclk_rise = s_sclk & ~sclk_d & ~s_cs_n;
  wire sclk_fall = ~s_sclk & sclk_d & ~s_cs_n;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= s_sclk;
    end
  end

  // Frame state
  multi_io_read_pkg::phase_type phase;
  multi_io_read_pkg::phase_type next_phase;
  logic [7:0]  cmd;
  logic [3:0]  cnt;
  logic [31:0] sh;
  logic        continuous;
  logic [2:0]  wrap_bits;

  wire in_code  = (phase == multi_io_read_pkg::PH_CODE);
  wire in_addr  = (phase == multi_io_read_pkg::PH_ADDR);
  wire in_mode  = (phase == multi_io_read_pkg::PH_MODE);
  wire in_dummy = (phase == multi_io_read_pkg::PH_DUMMY);
  wire in_data  = (phase == multi_io_read_pkg::PH_DATA);

  // Command decode of the stored code
  wire cmd_dual  = (cmd == `CMD_DUAL_IO_READ);
  wire cmd_quad  = (cmd == `CMD_QUAD_IO_READ);
  wire cmd_word  = (cmd == `CMD_WORD_QUAD_READ);
  wire cmd_octal = (cmd == `CMD_OCTAL_QUAD_READ);
  wire cmd_wrap  = (cmd == `CMD_SET_BURST_WRAP);

  // Code sent on IO0 alone, address on two or four lines
  wire [31:0] sh_next =
    in_code  ? {sh[30:0], s_io[0]} :
    cmd_dual ? {sh[29:0], s_io[1:0]} :
               {sh[27:0], s_io};

  wire [7:0] code_byte = sh_next[7:0];
  wire code_is_dual  = (code_byte == `CMD_DUAL_IO_READ);
  wire code_is_quad  = (code_byte == `CMD_QUAD_IO_READ) |
                       (code_byte == `CMD_WORD_QUAD_READ) |
                       (code_byte == `CMD_OCTAL_QUAD_READ);
  wire code_is_wrap  = (code_byte == `CMD_SET_BURST_WRAP);
  // Quad forms refused when quad lines are not enabled
  wire code_accept   = code_is_dual | code_is_wrap |
                       (code_is_quad & i_quad_lines_enable);

  // Phase lengths for the stored command
  wire [3:0] addr_len  = cmd_dual ? `ADDR_CLOCKS_DUAL : `ADDR_CLOCKS_QUAD;
  wire [3:0] mode_len  = cmd_dual ? `MODE_CLOCKS_DUAL : `MODE_CLOCKS_QUAD;
  wire [3:0] dummy_len =
    cmd_quad ? `DUMMY_CLOCKS_QUAD :
    cmd_word ? `DUMMY_CLOCKS_WORD :
               `DUMMY_CLOCKS_OCTAL;

  wire [3:0] phase_len =
    in_code  ? `CODE_CLOCKS :
    in_addr  ? addr_len :
    in_mode  ? mode_len :
    in_dummy ? dummy_len : 4'h0;

  wire last_clk  = (cnt == phase_len - 4'h1);
  wire step_done = sclk_rise & last_clk;
  wire code_done = step_done & in_code;
  wire addr_done = step_done & in_addr;
  wire mode_done = step_done & in_mode;

  // Host may send unaligned low bits; they are forced to zero
  wire [23:0] addr_raw = sh_next[23:0];
  wire [23:0] addr_aligned =
    cmd_word  ? {addr_raw[23:1], 1'h0} :
    cmd_octal ? {addr_raw[23:4], 4'h0} :
                addr_raw;

  always_comb begin
    next_phase = phase;
    if (s_cs_n) begin
      // Stored skip-code state picks where the next frame starts
      next_phase = continuous ? multi_io_read_pkg::PH_ADDR
                              : multi_io_read_pkg::PH_CODE;
    end else if (step_done) begin
      case (phase)
        multi_io_read_pkg::PH_CODE: begin
          next_phase = code_accept ? multi_io_read_pkg::PH_ADDR
                                   : multi_io_read_pkg::PH_IGNORE;
        end
        multi_io_read_pkg::PH_ADDR: begin
          next_phase = multi_io_read_pkg::PH_MODE;
        end
        multi_io_read_pkg::PH_MODE: begin
          if (cmd_wrap) begin
            next_phase = multi_io_read_pkg::PH_IGNORE;
          end else if (dummy_len == 4'h0) begin
            next_phase = multi_io_read_pkg::PH_DATA;
          end else begin
            next_phase = multi_io_read_pkg::PH_DUMMY;
          end
        end
        multi_io_read_pkg::PH_DUMMY: begin
          next_phase = multi_io_read_pkg::PH_DATA;
        end
        default: begin
          next_phase = phase;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      phase <= multi_io_read_pkg::PH_CODE;
      cnt   <= 4'h0;
      sh    <= 32'h0;
    end else begin
      phase <= next_phase;
      if (s_cs_n || step_done) begin
        cnt <= 4'h0;
      end else if (sclk_rise) begin
        cnt <= cnt + 4'h1;
      end
      if (sclk_rise) begin
        sh <= sh_next;
      end
    end
  end

  // Command, skip-code state and wrap setting
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd        <= 8'h00;
      continuous <= 1'b0;
      wrap_bits  <= `WRAP_BITS_RESET;
    end else begin
      if (code_done && code_accept) begin
        cmd <= code_byte;
      end
      if (mode_done && cmd_wrap) begin
        wrap_bits <= sh_next[`WRAP_BITS_HI:`WRAP_BITS_LO];
      end else if (mode_done) begin
        // Only bits 5-4 matter; FFh or FFFFh lands here as 11
        continuous <= (sh_next[`SKIP_CODE_HI:`SKIP_CODE_LO]
                       == `SKIP_CODE_KEY);
      end
    end
  end

  // Wrap applies to quad and word reads only, while bit 4 is zero
  wire       wrap_active = ~wrap_bits[0] & (cmd_quad | cmd_word);
  wire [1:0] wrap_len_sel = wrap_bits[2:1];

  function automatic logic [23:0] step_addr(
    input logic [23:0] a,
    input logic        wrap_en,
    input logic [1:0]  len_sel
  );
    logic [7:0] span;
    logic [7:0] mask;
    logic [7:0] low_inc;
    span    = 8'h08 << len_sel;
    mask    = span - 8'h01;
    low_inc = a[7:0] + 8'h01;
    if (wrap_en) begin
      step_addr = {a[23:8], (a[7:0] & ~mask) | (low_inc & mask)};
    end else begin
      step_addr = a + 24'h000001;
    end
  endfunction

  // Prefetch into the FIFO, one read in flight at a time
  logic fetch_active;
  logic ret_pend;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  wire fetch_issue = fetch_active & fifo_in_ready & ~o_mem_rd & ~ret_pend
                     & ~s_cs_n;
  wire fetch_push  = ret_pend & fetch_active;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      fetch_active <= 1'b0;
      o_mem_rd     <= 1'b0;
      ret_pend     <= 1'b0;
      o_mem_addr   <= 24'h0;
    end else if (s_cs_n) begin
      fetch_active <= 1'b0;
      o_mem_rd     <= 1'b0;
      ret_pend     <= 1'b0;
    end else begin
      o_mem_rd <= fetch_issue;
      ret_pend <= o_mem_rd;
      if (addr_done && !cmd_wrap) begin
        fetch_active <= 1'b1;
        o_mem_addr   <= addr_aligned;
      end else if (ret_pend) begin
        o_mem_addr <= step_addr(o_mem_addr, wrap_active, wrap_len_sel);
      end
    end
  end

  // Serial output; bytes are popped on the first beat of each
  logic [7:0] out_sh;
  logic [1:0] beat;

  wire       fifo_pop  = sclk_fall & in_data & (beat == 2'h0);
  wire [7:0] head_byte = fifo_out_valid ? fifo_out_data : 8'hFF;
  wire [7:0] cur_byte  = (beat == 2'h0) ? head_byte : out_sh;
  wire [1:0] last_beat = cmd_dual ? `BEATS_DUAL : `BEATS_QUAD;

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_flush     (s_cs_n),
    .i_in_valid  (fetch_push),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (i_mem_rdata),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_out_data)
  );

  // Lines are driven only from the first data falling edge on
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_io    <= 4'h0;
      o_io_oe <= 4'h0;
      out_sh  <= 8'h00;
      beat    <= 2'h0;
    end else if (s_cs_n) begin
      o_io    <= 4'h0;
      o_io_oe <= 4'h0;
      beat    <= 2'h0;
    end else if (sclk_fall && in_data) begin
      o_io_oe <= cmd_dual ? 4'h3 : 4'hF;
      o_io    <= cmd_dual ? {2'h0, cur_byte[7:6]} : cur_byte[7:4];
      out_sh  <= cmd_dual ? {cur_byte[5:0], 2'h0} : {cur_byte[3:0], 4'h0};
      beat    <= (beat == last_beat) ? 2'h0 : beat + 2'h1;
    end
  end

  // Status
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_continuous <= 1'b0;
      o_wrap_bits  <= `WRAP_BITS_RESET;
    end else begin
      o_continuous <= continuous;
      o_wrap_bits  <= wrap_bits;
    end
  end

endmodule

// file: spi_host_model.sv
/*
  Behavioural SPI mode 0 host that clocks flash read frames.
  Assumes the bench resolves the shared lines from the device's enables alone.
*/
`timescale 1ns/1ps
module spi_host_model (
  // Clock
  input  wire logic       i_core_clk,
  // Link
  output logic            o_cs_n,
  output logic            o_sclk,
  output logic      [3:0] o_io,
  input  wire logic [3:0] i_io
);
  logic       toggle = 1'b0;
  logic [3:0] drive = 4'h0;
  logic [3:0] lines_oe = 4'h0;

  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
  end
  always @(posedge i_core_clk) toggle <= ~toggle;
  // Released lines flip every cycle so stale data cannot pass
  assign o_io = (drive & lines_oe) | ({4{toggle}} & ~lines_oe);

  // Drive on the low half, sample late in the high half
  task automatic beat(input logic [3:0] v, input logic [3:0] oe,
                      output logic [3:0] got);
    @(posedge i_core_clk);
    o_sclk   <= 1'b0;
    drive    <= v;
    lines_oe <= oe;
    repeat (4) @(posedge i_core_clk);
    o_sclk <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    got = i_io;
  endtask

  task automatic start_frame();
    @(posedge i_core_clk);
    o_cs_n <= 1'b0;
    repeat (3) @(posedge i_core_clk);
  endtask

  task automatic end_frame();
    @(posedge i_core_clk);
    o_sclk   <= 1'b0;
    lines_oe <= 4'h0;
    repeat (4) @(posedge i_core_clk);
    o_cs_n <= 1'b1;
    repeat (8) @(posedge i_core_clk);
  endtask
endmodule

// file: multi_io_read_continuous_wrap_asserts.sv
/*
  Port-level checker for the multi-line read block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module multi_io_read_checker (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Watched ports
  input  wire logic        i_cs_n,
  input  wire logic        i_quad_lines_enable,
  input  wire logic [3:0]  o_io_oe,
  input  wire logic        o_continuous,
  input  wire logic [2:0]  o_wrap_bits,
  input  wire logic        o_mem_rd,
  input  wire logic [23:0] o_mem_addr
);
  logic        have;
  logic [23:0] last;
  logic [23:0] span;

  assign span = (24'h8 << o_wrap_bits[2:1]) - 24'h1;
  // First fetch of a frame has no predecessor to compare with
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      have <= 1'b0;
      last <= 24'h0;
    end else if (i_cs_n) begin
      have <= 1'b0;
    end else if (o_mem_rd) begin
      have <= 1'b1;
      last <= o_mem_addr;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  chk_idle_release:
    assert property (i_cs_n [*8] |-> o_io_oe == 4'h0)
    else $error("IO lines driven while deselected");
  chk_quad_gate:
    assert property (o_io_oe[3] |-> i_quad_lines_enable)
    else $error("Quad lines driven without quad enable");
  chk_line_groups:
    assert property (o_io_oe inside {4'h0, 4'h3, 4'hF})
    else $error("Odd group of driven lines");
  chk_linear_step:
    assert property (o_mem_rd && have && o_wrap_bits[0]
                     |-> o_mem_addr == last + 24'h1)
    else $error("Fetch address not linear");
  chk_wrap_step:
    assert property (o_mem_rd && have && !o_wrap_bits[0]
      |-> o_mem_addr == last + 24'h1 ||
          ((last & span) == span && o_mem_addr == (last & ~span)))
    else $error("Fetch address leaves wrap section");
  chk_fetch_gap:
    assert property (o_mem_rd |=> !o_mem_rd [*2])
    else $error("Fetches too close");
  chk_wrap_default:
    assert property ($fell(i_rst) |-> o_wrap_bits == 3'h1)
    else $error("Wrap bits wrong after reset");
  chk_wrap_sticky:
    assert property (!$stable(o_wrap_bits) |-> !i_cs_n)
    else $error("Wrap bits changed outside a frame");
  chk_mode_sticky:
    assert property (!$stable(o_continuous) |-> !i_cs_n)
    else $error("Continuous state changed outside a frame");

  cover property ($rose(o_continuous));
  cover property (o_io_oe == 4'h3);
  cover property (o_io_oe == 4'hF);
  cover property (o_mem_rd && have && !o_wrap_bits[0] &&
                  (last & span) == span);
endmodule

bind multi_io_read_continuous_wrap multi_io_read_checker checker_inst (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_cs_n(i_cs_n),
  .i_quad_lines_enable(i_quad_lines_enable), .o_io_oe(o_io_oe),
  .o_continuous(o_continuous), .o_wrap_bits(o_wrap_bits),
  .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr)
);

// file: test_multi_io_read_continuous_wrap.sv
/*
  Self-checking bench for the multi-line read block with a host model.
  Assumes the design constants header and a one-cycle memory model.
*/
`timescale 1ns/1ps
`include "multi_io_read_cfg.svh"
module test_multi_io_read_continuous_wrap;
  logic        i_core_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        qe = 1'b0;
  logic [7:0]  mem_rdata = 8'h00;
  logic        cs_n, sclk, cont, mem_rd;
  logic [3:0]  host_io, dev_io, dev_oe, io_line, got;
  logic [2:0]  wbits;
  logic [2:0]  wrap = 3'h1;
  logic [23:0] mem_addr;
  logic [31:0] seed = 32'h2;
  logic [31:0] r;
  logic [7:0]  cmds [4] = '{`CMD_DUAL_IO_READ, `CMD_QUAD_IO_READ,
                            `CMD_WORD_QUAD_READ, `CMD_OCTAL_QUAD_READ};
  int          n_mismatch = 0;
  int          checks = 0;
  int          oe_cycles = 0;
  int          k;

  multi_io_read_continuous_wrap dut (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_io(io_line), .o_io(dev_io), .o_io_oe(dev_oe),
    .i_quad_lines_enable(qe), .o_continuous(cont), .o_wrap_bits(wbits),
    .o_mem_rd(mem_rd), .o_mem_addr(mem_addr), .i_mem_rdata(mem_rdata)
  );
  spi_host_model host (
    .i_core_clk(i_core_clk), .o_cs_n(cs_n), .o_sclk(sclk),
    .o_io(host_io), .i_io(io_line)
  );
  assign io_line = (dev_oe & dev_io) | (~dev_oe & host_io);

  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  initial begin
    forever #20 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    if (dev_oe !== 4'h0) oe_cycles++;
    if (mem_rd) mem_rdata <= mem(mem_addr);
  end

  task automatic chk(input string n, input logic [23:0] e, g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic send(input logic [31:0] v, input int bits, input int w);
    for (int i = bits - w; i >= 0; i -= w)
      host.beat(v[i+:4] & 4'((1 << w) - 1), 4'((1 << w) - 1), got);
  endtask

  task automatic rd(input logic [7:0] c, input bit skip,
                    input logic [23:0] a, input logic [7:0] mode,
                    input int n);
    logic [23:0] m;
    logic [7:0]  byt;
    int          w;
    w = (c == `CMD_DUAL_IO_READ) ? 2 : 4;
    if (c == `CMD_WORD_QUAD_READ) a[0] = 1'b0;
    if (c == `CMD_OCTAL_QUAD_READ) a[3:0] = 4'h0;
    m = 24'((8 << wrap[2:1]) - 1);
    host.start_frame();
    if (!skip) send(c, 8, 1);
    send(a, 24, w);
    send(mode, 8, w);
    repeat (c == `CMD_QUAD_IO_READ ? 4 : c == `CMD_WORD_QUAD_READ ? 2 : 0)
      host.beat(4'h0, 4'h0, got);
    for (int b = 0; b < n; b++) begin
      byt = 8'h00;
      repeat (8 / w) begin
        host.beat(4'h0, 4'h0, got);
        byt = (byt << w) | {4'h0, got & 4'((1 << w) - 1)};
      end
      chk("read data", mem(a), byt);
      if (!wrap[0] && w == 4 && c != `CMD_OCTAL_QUAD_READ)
        a = (a & ~m) | ((a + 24'h1) & m);
      else
        a = a + 24'h1;
    end
    host.end_frame();
  endtask

  task automatic set_wrap(input logic [2:0] wb);
    host.start_frame();
    send(`CMD_SET_BURST_WRAP, 8, 1);
    send({24'h0, 1'b0, wb, 4'h0}, 32, 4);
    host.end_frame();
    wrap = wb;
    chk("wrap bits", wb, wbits);
  endtask

  task automatic stop_test();
    $display("Counts: %0d checks, %0d mismatches", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge i_core_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    chk("wrap reset", 3'h1, wbits);
    for (int j = 1; j < 4; j++) begin
      k = oe_cycles;
      rd(cmds[j], 1'b0, 24'(rnd()), 8'hA0, 0);
      chk("refused drive", 24'(k), 24'(oe_cycles));
      chk("refused mode", 1'b0, cont);
    end
    $display("Test refusal done");
    qe <= 1'b1;
    foreach (cmds[j]) begin
      r = rnd();
      rd(cmds[j], 1'b0, {r[23:8], 8'hFE}, {r[7:6], 2'b10, r[3:0]}, 3);
      chk("mode kept", 1'b1, cont);
      r = rnd();
      rd(cmds[j], 1'b1, r[23:0], {r[7:5], 1'b1, r[3:0]}, 3);
      chk("mode cleared", 1'b0, cont);
      rd(cmds[j], 1'b0, 24'(rnd()), 8'h00, 2);
    end
    $display("Test continuous read done");
    for (int j = 0; j < 2; j++) begin
      rd(cmds[j], 1'b0, 24'(rnd()), 8'h20, 1);
      rd(cmds[j], 1'b1, 24'hFFFFFF, 8'hFF, 0);
      chk("mode reset", 1'b0, cont);
    end
    $display("Test mode reset done");
    for (int l = 0; l < 4; l++) begin
      set_wrap({l[1:0], 1'b0});
      rd(cmds[1 + l % 2], 1'b0, 24'(rnd()), 8'h00, (8 << l) + 2);
    end
    rd(cmds[0], 1'b0, {r[23:6], 6'h3E}, 8'h00, 4);
    set_wrap(3'h7);
    rd(cmds[1], 1'b0, {r[23:6], 6'h3E}, 8'h00, 4);
    $display("Test wrap done");
    stop_test();
  end

  // Whole run needs well under a third of this span
  initial begin
    #2000000;
    n_mismatch++;
    $display("Error watchdog expected end seen timeout");
    stop_test();
  end
endmodule
